// File: logic/ofs_regs.vh
// constants for the oscillator fault and fail-safe clock switch
`ifndef OFS_REGS_VH
`define OFS_REGS_VH

// clock source select encodings (shared by master, subsystem and auxiliary selects)
`define OFS_SRC_XT1 3'h0
`define OFS_SRC_VLO 3'h1
`define OFS_SRC_TRIMMED_REFERENCE_OSCILLATOR 3'h2
`define OFS_SRC_DCO 3'h3
`define OFS_SRC_DCODIV 3'h4
`define OFS_SRC_XT2 3'h5
`define OFS_SRC_W 3
`define OFS_NUM_SRC 6

// loop reference select encodings
`define OFS_REF_XT1 3'h0
`define OFS_REF_TRIMMED_REFERENCE_OSCILLATOR 3'h2
`define OFS_REF_XT2 3'h5

// tap select field limits and location in the first control register
`define OFS_TAP_W 5
`define OFS_TAP_LSB 8
`define OFS_TAP_MSB 12
`define OFS_TAP_MIN 5'h00
`define OFS_TAP_MAX 5'h1F

// fault-clear counter maxima, counted in crystal clock edges
`define OFS_CNT_W 14
`define OFS_CNT_MAX_LF 8192
`define OFS_CNT_MAX_HF 1024
`define OFS_CNT_ZERO 14'h0000
`define OFS_CNT_ONE 14'h0001

// reset values
`define OFS_COMBINED_RESET 1'b1
`define OFS_IRQ_EN_RESET 1'b0

// switch state codes, one-hot
`define OFS_ST_RUN 3'h1
`define OFS_ST_FINISH 3'h2
`define OFS_ST_HOLD 3'h4

`endif

// File: logic/ofs_clk_switch.v
// glitch-free clock source switch working on sampled source levels
`timescale 1ns/1ps
`include "ofs_regs.vh"

module ofs_clk_switch (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // sampled source levels, indexed by source code
    input wire [`OFS_NUM_SRC-1:0] src_lvl,
    // requested source
    input wire [`OFS_SRC_W-1:0] sel,
    // sources known to be dead, indexed by source code
    input wire [`OFS_NUM_SRC-1:0] src_dead,
    // switched clock
    output reg clk_out,
    output wire [`OFS_SRC_W-1:0] cur_sel
);
    localparam [2:0] ST_RUN = `OFS_ST_RUN;
    localparam [2:0] ST_FINISH = `OFS_ST_FINISH;
    localparam [2:0] ST_HOLD = `OFS_ST_HOLD;

    reg [2:0] state_q;
    reg [`OFS_SRC_W-1:0] cur_q;
    reg [`OFS_SRC_W-1:0] new_q;
    reg [`OFS_NUM_SRC-1:0] prev_q;

    wire [`OFS_NUM_SRC-1:0] rise;

    // unmapped codes fall back to the divided controlled-oscillator clock
    function pick;
        input [`OFS_NUM_SRC-1:0] v;
        input [`OFS_SRC_W-1:0] idx;
        begin
            if (idx > `OFS_SRC_XT2) begin
                pick = v[`OFS_SRC_DCODIV];
            end else begin
                pick = v[idx];
            end
        end
    endfunction

    assign rise = src_lvl & ~prev_q;
    assign cur_sel = cur_q;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_RUN;
            cur_q <= `OFS_SRC_DCODIV;
            new_q <= `OFS_SRC_DCODIV;
            prev_q <= {`OFS_NUM_SRC{1'b0}};
            clk_out <= 1'b0;
        end else begin
            prev_q <= src_lvl;
            case (state_q)
                ST_RUN: begin
                    clk_out <= pick(src_lvl, cur_q);
                    if (sel != cur_q) begin
                        new_q <= sel;
                        state_q <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    // old cycle runs to its next rising edge; a dead source ends the wait
                    if (pick(rise, cur_q) || pick(src_dead, cur_q)) begin
                        clk_out <= 1'b1;
                        state_q <= ST_HOLD;
                    end else begin
                        clk_out <= pick(src_lvl, cur_q);
                    end
                end
                ST_HOLD: begin
                    // held high until the new source rises, then its full high period
                    clk_out <= 1'b1;
                    if (pick(rise, new_q)) begin
                        cur_q <= new_q;
                        state_q <= ST_RUN;
                    end else if (pick(src_dead, new_q) && (sel != new_q)) begin
                        // target died while waited for; retarget with output held high
                        new_q <= sel;
                    end
                end
                default: begin
                    state_q <= ST_RUN;
                    clk_out <= 1'b0;
                end
            endcase
        end
    end
endmodule // ofs_clk_switch

// File: logic/ofs_failsafe.v
// oscillator fault detection, fault flags and fail-safe clock selection
`timescale 1ns/1ps
`include "ofs_regs.vh"

module ofs_failsafe #(
    parameter integer CNT_MAX_LF = `OFS_CNT_MAX_LF,
    parameter integer CNT_MAX_HF = `OFS_CNT_MAX_HF
) (
    // clock and reset
    input wire REF_CLK,
    input wire RST_B,
    // crystal one status
    input wire XT1_ON,
    input wire XT1_HF_MODE,
    input wire XT1_BYPASS,
    input wire XT1_RUNNING,
    // crystal two status
    input wire XT2_ON,
    input wire XT2_BYPASS,
    input wire XT2_RUNNING,
    // sampled source clock levels
    input wire XT1_CLK,
    input wire VLO_CLK,
    input wire TRIMMED_REFERENCE_OSCILLATOR_CLK,
    input wire DCO_CLK,
    input wire DCO_DIV_CLK,
    input wire XT2_CLK,
    // loop state
    input wire [`OFS_TAP_W-1:0] TAP_SELECT_FIELD,
    input wire [`OFS_SRC_W-1:0] LOOP_REFERENCE_SELECT,
    input wire SIGMA_DELTA_CLOCK_FAULT,
    // software source selects
    input wire [`OFS_SRC_W-1:0] MASTER_SOURCE_SELECT,
    input wire [`OFS_SRC_W-1:0] SUBSYSTEM_SOURCE_SELECT,
    input wire [`OFS_SRC_W-1:0] AUXILIARY_SOURCE_SELECT,
    // software flag clears, one-cycle pulses
    input wire CLR_XTAL1_LOW_FREQ_FAULT_FLAG,
    input wire CLR_XTAL1_HIGH_FREQ_FAULT_FLAG,
    input wire CLR_XTAL2_FAULT_FLAG,
    input wire CLR_CTRL_OSC_FAULT_FLAG,
    input wire CLR_COMBINED_FAULT_IRQ_FLAG,
    // interrupt enable write
    input wire FAULT_IRQ_ENABLE_WR,
    input wire FAULT_IRQ_ENABLE_DATA,
    // flags
    output reg XTAL1_LOW_FREQ_FAULT_FLAG,
    output reg XTAL1_HIGH_FREQ_FAULT_FLAG,
    output reg XTAL2_FAULT_FLAG,
    output reg CTRL_OSC_FAULT_FLAG,
    output reg COMBINED_FAULT_IRQ_FLAG,
    output reg FAULT_IRQ_ENABLE,
    output wire NMI_REQ,
    // internal crystal fault signals
    output reg XT1_FAULT_SIGNAL,
    output reg XT2_FAULT_SIGNAL,
    // clocks
    output reg LOOP_REFERENCE_CLOCK,
    output wire MASTER_CLOCK,
    output wire SUBSYSTEM_CLOCK,
    output wire AUXILIARY_CLOCK,
    // fail-safe substitution active per clock
    output reg MASTER_FAILSAFE,
    output reg SUBSYSTEM_FAILSAFE,
    output reg AUXILIARY_FAILSAFE
);
    reg [`OFS_CNT_W-1:0] xt1_cnt_q;
    reg [`OFS_CNT_W-1:0] xt2_cnt_q;
    reg xt1_clk_prev_q;
    reg xt2_clk_prev_q;
    reg xt1_hf_at_fault_q;
    reg [1:0] xt1_sync_q;
    reg [1:0] xt2_sync_q;

    wire xt1_rise;
    wire xt2_rise;
    wire xt1_fault;
    wire xt2_fault;
    wire xt1_lf_cond;
    wire xt1_hf_cond;
    wire dco_cond;
    wire any_fault;
    wire restore;
    wire [`OFS_NUM_SRC-1:0] src_lvl;
    wire [`OFS_NUM_SRC-1:0] src_dead;
    wire [`OFS_SRC_W-1:0] master_eff;
    wire [`OFS_SRC_W-1:0] subsys_eff;
    wire [`OFS_SRC_W-1:0] aux_eff;

    // counter maximum for the crystal mode
    function [`OFS_CNT_W-1:0] cnt_limit;
        input hf;
        input bypass;
        begin
            if (hf && !bypass) begin
                cnt_limit = CNT_MAX_HF[`OFS_CNT_W-1:0];
            end else begin
                cnt_limit = CNT_MAX_LF[`OFS_CNT_W-1:0];
            end
        end
    endfunction

    // is the selected source a faulted crystal
    function src_faulted;
        input [`OFS_SRC_W-1:0] sel;
        input f1;
        input f2;
        begin
            src_faulted = ((sel == `OFS_SRC_XT1) && f1) || ((sel == `OFS_SRC_XT2) && f2);
        end
    endfunction

    // backup source: trimmed oscillator for low-freq crystal one, else divided clock
    function [`OFS_SRC_W-1:0] backup_src;
        input [`OFS_SRC_W-1:0] sel;
        input hf;
        begin
            if ((sel == `OFS_SRC_XT1) && !hf) begin
                backup_src = `OFS_SRC_TRIMMED_REFERENCE_OSCILLATOR;
            end else begin
                backup_src = `OFS_SRC_DCODIV;
            end
        end
    endfunction

    assign xt1_rise = XT1_CLK & ~xt1_clk_prev_q;
    assign xt2_rise = XT2_CLK & ~xt2_clk_prev_q;

    // crystal fault counters: restart on fault, count edges after recovery
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            xt1_cnt_q <= `OFS_CNT_ZERO;
            xt2_cnt_q <= `OFS_CNT_ZERO;
            XT1_FAULT_SIGNAL <= 1'b0;
            XT2_FAULT_SIGNAL <= 1'b0;
            xt1_clk_prev_q <= 1'b0;
            xt2_clk_prev_q <= 1'b0;
        end else begin
            xt1_clk_prev_q <= XT1_CLK;
            xt2_clk_prev_q <= XT2_CLK;
            if (!XT1_ON) begin
                XT1_FAULT_SIGNAL <= 1'b0;
                xt1_cnt_q <= `OFS_CNT_ZERO;
            end else if (!XT1_RUNNING) begin
                XT1_FAULT_SIGNAL <= 1'b1;
                xt1_cnt_q <= `OFS_CNT_ZERO;
            end else if (XT1_FAULT_SIGNAL && xt1_rise) begin
                xt1_cnt_q <= xt1_cnt_q + `OFS_CNT_ONE;
                if (xt1_cnt_q + `OFS_CNT_ONE >= cnt_limit(XT1_HF_MODE, XT1_BYPASS)) begin
                    XT1_FAULT_SIGNAL <= 1'b0;
                end
            end
            if (!XT2_ON) begin
                XT2_FAULT_SIGNAL <= 1'b0;
                xt2_cnt_q <= `OFS_CNT_ZERO;
            end else if (!XT2_RUNNING) begin
                XT2_FAULT_SIGNAL <= 1'b1;
                xt2_cnt_q <= `OFS_CNT_ZERO;
            end else if (XT2_FAULT_SIGNAL && xt2_rise) begin
                xt2_cnt_q <= xt2_cnt_q + `OFS_CNT_ONE;
                if (xt2_cnt_q + `OFS_CNT_ONE >= cnt_limit(1'b1, XT2_BYPASS)) begin
                    XT2_FAULT_SIGNAL <= 1'b0;
                end
            end
        end
    end

    // two-stage synchronisers; first stage feeds only the second
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            xt1_sync_q <= 2'b00;
            xt2_sync_q <= 2'b00;
            xt1_hf_at_fault_q <= 1'b0;
        end else begin
            xt1_sync_q <= {xt1_sync_q[0], XT1_FAULT_SIGNAL};
            xt2_sync_q <= {xt2_sync_q[0], XT2_FAULT_SIGNAL};
            xt1_hf_at_fault_q <= XT1_HF_MODE;
        end
    end

    assign xt1_fault = xt1_sync_q[1];
    assign xt2_fault = xt2_sync_q[1];
    assign xt1_lf_cond = xt1_fault && !xt1_hf_at_fault_q;
    assign xt1_hf_cond = xt1_fault && xt1_hf_at_fault_q;
    // tap field arrives as bits twelve to eight of the first control register
    assign dco_cond = (TAP_SELECT_FIELD == `OFS_TAP_MIN) ||
                      (TAP_SELECT_FIELD == `OFS_TAP_MAX);
    assign any_fault = xt1_lf_cond | xt1_hf_cond | xt2_fault | dco_cond |
                       SIGMA_DELTA_CLOCK_FAULT;
    assign restore = CLR_COMBINED_FAULT_IRQ_FLAG && !any_fault;

    // sticky flags; a live condition wins over a software clear
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            XTAL1_LOW_FREQ_FAULT_FLAG <= 1'b0;
            XTAL1_HIGH_FREQ_FAULT_FLAG <= 1'b0;
            XTAL2_FAULT_FLAG <= 1'b0;
            CTRL_OSC_FAULT_FLAG <= 1'b0;
            COMBINED_FAULT_IRQ_FLAG <= `OFS_COMBINED_RESET;
            FAULT_IRQ_ENABLE <= `OFS_IRQ_EN_RESET;
        end else begin
            XTAL1_LOW_FREQ_FAULT_FLAG <= xt1_lf_cond |
                (XTAL1_LOW_FREQ_FAULT_FLAG & ~CLR_XTAL1_LOW_FREQ_FAULT_FLAG);
            XTAL1_HIGH_FREQ_FAULT_FLAG <= xt1_hf_cond |
                (XTAL1_HIGH_FREQ_FAULT_FLAG & ~CLR_XTAL1_HIGH_FREQ_FAULT_FLAG);
            XTAL2_FAULT_FLAG <= xt2_fault |
                (XTAL2_FAULT_FLAG & ~CLR_XTAL2_FAULT_FLAG);
            CTRL_OSC_FAULT_FLAG <= dco_cond |
                (CTRL_OSC_FAULT_FLAG & ~CLR_CTRL_OSC_FAULT_FLAG);
            COMBINED_FAULT_IRQ_FLAG <= any_fault |
                (COMBINED_FAULT_IRQ_FLAG & ~CLR_COMBINED_FAULT_IRQ_FLAG);
            // only software writes change the enable; grant has no effect
            if (FAULT_IRQ_ENABLE_WR) begin
                FAULT_IRQ_ENABLE <= FAULT_IRQ_ENABLE_DATA;
            end
        end
    end

    assign NMI_REQ = COMBINED_FAULT_IRQ_FLAG & FAULT_IRQ_ENABLE;

    // fail-safe substitution, held until combined flag cleared with no fault
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            MASTER_FAILSAFE <= 1'b0;
            SUBSYSTEM_FAILSAFE <= 1'b0;
            AUXILIARY_FAILSAFE <= 1'b0;
        end else begin
            MASTER_FAILSAFE <= src_faulted(MASTER_SOURCE_SELECT, xt1_fault, xt2_fault) |
                (MASTER_FAILSAFE & ~restore);
            SUBSYSTEM_FAILSAFE <= src_faulted(SUBSYSTEM_SOURCE_SELECT, xt1_fault, xt2_fault) |
                (SUBSYSTEM_FAILSAFE & ~restore);
            AUXILIARY_FAILSAFE <= src_faulted(AUXILIARY_SOURCE_SELECT, xt1_fault, xt2_fault) |
                (AUXILIARY_FAILSAFE & ~restore);
        end
    end

    // select inputs are never altered; only the effective choice changes
    assign master_eff = MASTER_FAILSAFE ?
        backup_src(MASTER_SOURCE_SELECT, xt1_hf_at_fault_q) : MASTER_SOURCE_SELECT;
    assign subsys_eff = SUBSYSTEM_FAILSAFE ?
        backup_src(SUBSYSTEM_SOURCE_SELECT, xt1_hf_at_fault_q) : SUBSYSTEM_SOURCE_SELECT;
    assign aux_eff = AUXILIARY_FAILSAFE ?
        backup_src(AUXILIARY_SOURCE_SELECT, xt1_hf_at_fault_q) : AUXILIARY_SOURCE_SELECT;

    // divided clock passes straight through; it never depends on the tap
    assign src_lvl = {XT2_CLK, DCO_DIV_CLK, DCO_CLK, TRIMMED_REFERENCE_OSCILLATOR_CLK, VLO_CLK, XT1_CLK};
    // a faulted crystal gives no edges for a switch to wait on
    assign src_dead = {xt2_fault, 4'h0, xt1_fault};

    // loop reference selection
    always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            LOOP_REFERENCE_CLOCK <= 1'b0;
        end else begin
            case (LOOP_REFERENCE_SELECT)
                `OFS_REF_XT1: begin
                    if (xt1_lf_cond) begin
                        LOOP_REFERENCE_CLOCK <= TRIMMED_REFERENCE_OSCILLATOR_CLK;
                    end else if (xt1_hf_cond) begin
                        LOOP_REFERENCE_CLOCK <= 1'b0;
                    end else begin
                        LOOP_REFERENCE_CLOCK <= XT1_CLK;
                    end
                end
                `OFS_REF_XT2: begin
                    LOOP_REFERENCE_CLOCK <= xt2_fault ? 1'b0 : XT2_CLK;
                end
                default: begin
                    LOOP_REFERENCE_CLOCK <= TRIMMED_REFERENCE_OSCILLATOR_CLK;
                end
            endcase
        end
    end

    ofs_clk_switch u_master_sw (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .src_lvl(src_lvl),
        .src_dead(src_dead),
        .sel(master_eff),
        .clk_out(MASTER_CLOCK),
        .cur_sel()
    );

    ofs_clk_switch u_subsys_sw (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .src_lvl(src_lvl),
        .src_dead(src_dead),
        .sel(subsys_eff),
        .clk_out(SUBSYSTEM_CLOCK),
        .cur_sel()
    );

    ofs_clk_switch u_aux_sw (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .src_lvl(src_lvl),
        .src_dead(src_dead),
        .sel(aux_eff),
        .clk_out(AUXILIARY_CLOCK),
        .cur_sel()
    );
endmodule // ofs_failsafe

// File: verif/ofs_failsafe_assertions.sv
// concurrent checks on the ports of the fail-safe clock block
`timescale 1ns/1ps
module ofs_failsafe_assertions #(
    parameter integer CNT_MAX_LF = 8192,
    parameter integer CNT_MAX_HF = 1024
) (
    // clock and reset
    input wire REF_CLK,
    input wire RST_B,
    // inputs watched
    input wire XT1_ON,
    input wire XT1_RUNNING,
    input wire XT2_ON,
    input wire XT2_RUNNING,
    input wire [4:0] TAP_SELECT_FIELD,
    input wire [2:0] LOOP_REFERENCE_SELECT,
    input wire [2:0] MASTER_SOURCE_SELECT,
    input wire CLR_XTAL1_LOW_FREQ_FAULT_FLAG,
    input wire CLR_COMBINED_FAULT_IRQ_FLAG,
    input wire FAULT_IRQ_ENABLE_WR,
    // outputs watched
    input wire XTAL1_LOW_FREQ_FAULT_FLAG,
    input wire CTRL_OSC_FAULT_FLAG,
    input wire COMBINED_FAULT_IRQ_FLAG,
    input wire FAULT_IRQ_ENABLE,
    input wire NMI_REQ,
    input wire XT1_FAULT_SIGNAL,
    input wire LOOP_REFERENCE_CLOCK,
    input wire MASTER_CLOCK,
    input wire SUBSYSTEM_CLOCK,
    input wire AUXILIARY_CLOCK,
    input wire MASTER_FAILSAFE,
    input wire AUXILIARY_FAILSAFE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    AST_NMI_AND: assert property (NMI_REQ == (COMBINED_FAULT_IRQ_FLAG && FAULT_IRQ_ENABLE))
        else $error("nmi request differs from flag and enable");
    AST_DCO_SET: assert property ((TAP_SELECT_FIELD == 5'h00 || TAP_SELECT_FIELD == 5'h1F)
        |=> CTRL_OSC_FAULT_FLAG) else $error("tap limit did not set oscillator flag");
    AST_DCO_COMB: assert property ((TAP_SELECT_FIELD == 5'h00 || TAP_SELECT_FIELD == 5'h1F)
        |-> ##[1:2] COMBINED_FAULT_IRQ_FLAG) else $error("tap limit did not set combined flag");
    AST_XT1_SIG: assert property (XT1_ON && !XT1_RUNNING |=> XT1_FAULT_SIGNAL)
        else $error("stopped crystal one gave no fault signal");
    AST_XT1_STICKY: assert property ($fell(XTAL1_LOW_FREQ_FAULT_FLAG)
        |-> $past(CLR_XTAL1_LOW_FREQ_FAULT_FLAG)) else $error("crystal flag dropped unasked");
    AST_COMB_STICKY: assert property ($fell(COMBINED_FAULT_IRQ_FLAG)
        |-> $past(CLR_COMBINED_FAULT_IRQ_FLAG)) else $error("combined flag dropped unasked");
    AST_EN_HOLD: assert property (!FAULT_IRQ_ENABLE_WR |=> $stable(FAULT_IRQ_ENABLE))
        else $error("enable changed without a write");
    AST_MASTER_SUB: assert property ((MASTER_SOURCE_SELECT == 3'h0 && XT1_ON && !XT1_RUNNING)[*6]
        |-> MASTER_FAILSAFE) else $error("master clock not substituted");
    AST_FS_RESTORE: assert property ($fell(MASTER_FAILSAFE)
        |-> $past(CLR_COMBINED_FAULT_IRQ_FLAG)) else $error("substitution ended unasked");
    AST_REF_NONE: assert property ((LOOP_REFERENCE_SELECT == 3'h5 && XT2_ON && !XT2_RUNNING)[*6]
        |-> !LOOP_REFERENCE_CLOCK) else $error("reference clock present from faulted crystal");
    AST_M_HIGH: assert property ($rose(MASTER_CLOCK) |=> MASTER_CLOCK)
        else $error("master clock high phase cut short");
    AST_S_LOW: assert property ($fell(SUBSYSTEM_CLOCK) |=> !SUBSYSTEM_CLOCK)
        else $error("subsystem clock low phase cut short");
    AST_M_ALIVE: assert property ($rose(MASTER_FAILSAFE) |-> ##[1:60] $rose(MASTER_CLOCK))
        else $error("master clock stalled after substitution");
    AST_A_ALIVE: assert property ($rose(AUXILIARY_FAILSAFE) |-> ##[1:60] $rose(AUXILIARY_CLOCK))
        else $error("auxiliary clock stalled after substitution");
endmodule // ofs_failsafe_assertions

bind ofs_failsafe ofs_failsafe_assertions #(.CNT_MAX_LF(CNT_MAX_LF), .CNT_MAX_HF(CNT_MAX_HF)) u_chk (
    .REF_CLK(REF_CLK), .RST_B(RST_B), .XT1_ON(XT1_ON), .XT1_RUNNING(XT1_RUNNING),
    .XT2_ON(XT2_ON), .XT2_RUNNING(XT2_RUNNING), .TAP_SELECT_FIELD(TAP_SELECT_FIELD),
    .LOOP_REFERENCE_SELECT(LOOP_REFERENCE_SELECT), .MASTER_SOURCE_SELECT(MASTER_SOURCE_SELECT),
    .CLR_XTAL1_LOW_FREQ_FAULT_FLAG(CLR_XTAL1_LOW_FREQ_FAULT_FLAG),
    .CLR_COMBINED_FAULT_IRQ_FLAG(CLR_COMBINED_FAULT_IRQ_FLAG),
    .FAULT_IRQ_ENABLE_WR(FAULT_IRQ_ENABLE_WR), .XTAL1_LOW_FREQ_FAULT_FLAG(XTAL1_LOW_FREQ_FAULT_FLAG),
    .CTRL_OSC_FAULT_FLAG(CTRL_OSC_FAULT_FLAG), .AUXILIARY_CLOCK(AUXILIARY_CLOCK),
    .AUXILIARY_FAILSAFE(AUXILIARY_FAILSAFE),
    .COMBINED_FAULT_IRQ_FLAG(COMBINED_FAULT_IRQ_FLAG), .FAULT_IRQ_ENABLE(FAULT_IRQ_ENABLE),
    .NMI_REQ(NMI_REQ), .XT1_FAULT_SIGNAL(XT1_FAULT_SIGNAL),
    .LOOP_REFERENCE_CLOCK(LOOP_REFERENCE_CLOCK), .MASTER_CLOCK(MASTER_CLOCK),
    .SUBSYSTEM_CLOCK(SUBSYSTEM_CLOCK), .MASTER_FAILSAFE(MASTER_FAILSAFE));

// File: verif/ofs_osc_model.sv
// behavioural oscillators feeding the fail-safe block
`timescale 1ns/1ps
module ofs_osc_model (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // crystal stop requests
    input wire xt1_stop,
    input wire xt2_stop,
    // source levels by source code, crystal status
    output reg [5:0] src,
    output wire xt1_ok,
    output wire xt2_ok
);
    integer cnt;
    assign xt1_ok = !xt1_stop;
    assign xt2_ok = !xt2_stop;
    // a stopped crystal freezes at its last level
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 0;
            src <= 6'h00;
        end else begin
            cnt <= cnt + 1;
            if (!xt1_stop) src[0] <= (cnt % 6) >= 3;
            src[1] <= (cnt % 14) >= 7;
            src[2] <= (cnt % 8) >= 4;
            src[3] <= (cnt % 4) >= 2;
            src[4] <= (cnt % 10) >= 5;
            if (!xt2_stop) src[5] <= (cnt % 4) >= 2;
        end
    end
endmodule // ofs_osc_model

// File: verif/test_ofs_failsafe.sv
// self-checking bench for the oscillator fault and fail-safe block
`timescale 1ns/1ps
module test_ofs_failsafe;
    localparam integer LF = 16;
    localparam integer HF = 8;
    reg REF_CLK = 1'b0;
    reg RST_B = 1'b0;
    reg xt1_on = 1'b0, xt1_hf = 1'b0, xt1_byp = 1'b0, xt2_on = 1'b0, xt2_byp = 1'b0;
    reg xt1_stop = 1'b0, xt2_stop = 1'b0, sdf = 1'b0, en_d = 1'b0, ref_seen = 1'b0;
    reg [4:0] tap = 5'h10;
    reg [2:0] ref_sel = 3'h2, msel = 3'h4, ssel = 3'h4, asel = 3'h4;
    reg [5:0] clr = 6'h00;
    reg [25:0] notes[$];
    reg [25:0] n;
    reg [12:0] fm, sm, mk, vl;
    integer error_cnt = 0, checked = 0, i, m, mx, per;
    wire [5:0] src;
    wire ok1, ok2, f_lf, f_hf, f_x2, f_dco, f_comb, f_en, nmi, s1, s2, lref, mfs, sfs, afs;
    wire [12:0] obs = {ref_seen, afs, sfs, mfs, s2, s1, nmi, f_en, f_comb, f_dco, f_x2, f_hf, f_lf};
    event note_ev;

    always #50 REF_CLK = ~REF_CLK;
    always @(posedge lref) ref_seen <= 1'b1;

    ofs_osc_model u_osc (.clk(REF_CLK), .rst_b(RST_B), .xt1_stop(xt1_stop), .xt2_stop(xt2_stop),
        .src(src), .xt1_ok(ok1), .xt2_ok(ok2));

    ofs_failsafe #(.CNT_MAX_LF(LF), .CNT_MAX_HF(HF)) u_dut (.REF_CLK(REF_CLK), .RST_B(RST_B),
        .XT1_ON(xt1_on), .XT1_HF_MODE(xt1_hf), .XT1_BYPASS(xt1_byp), .XT1_RUNNING(ok1),
        .XT2_ON(xt2_on), .XT2_BYPASS(xt2_byp), .XT2_RUNNING(ok2), .XT1_CLK(src[0]),
        .VLO_CLK(src[1]), .TRIMMED_REFERENCE_OSCILLATOR_CLK(src[2]), .DCO_CLK(src[3]), .DCO_DIV_CLK(src[4]),
        .XT2_CLK(src[5]), .TAP_SELECT_FIELD(tap), .LOOP_REFERENCE_SELECT(ref_sel),
        .SIGMA_DELTA_CLOCK_FAULT(sdf), .MASTER_SOURCE_SELECT(msel),
        .SUBSYSTEM_SOURCE_SELECT(ssel), .AUXILIARY_SOURCE_SELECT(asel),
        .CLR_XTAL1_LOW_FREQ_FAULT_FLAG(clr[0]), .CLR_XTAL1_HIGH_FREQ_FAULT_FLAG(clr[1]),
        .CLR_XTAL2_FAULT_FLAG(clr[2]), .CLR_CTRL_OSC_FAULT_FLAG(clr[3]),
        .CLR_COMBINED_FAULT_IRQ_FLAG(clr[4]), .FAULT_IRQ_ENABLE_WR(clr[5]),
        .FAULT_IRQ_ENABLE_DATA(en_d), .XTAL1_LOW_FREQ_FAULT_FLAG(f_lf),
        .XTAL1_HIGH_FREQ_FAULT_FLAG(f_hf), .XTAL2_FAULT_FLAG(f_x2), .CTRL_OSC_FAULT_FLAG(f_dco),
        .COMBINED_FAULT_IRQ_FLAG(f_comb), .FAULT_IRQ_ENABLE(f_en), .NMI_REQ(nmi),
        .XT1_FAULT_SIGNAL(s1), .XT2_FAULT_SIGNAL(s2), .LOOP_REFERENCE_CLOCK(lref),
        .MASTER_CLOCK(), .SUBSYSTEM_CLOCK(), .AUXILIARY_CLOCK(), .MASTER_FAILSAFE(mfs),
        .SUBSYSTEM_FAILSAFE(sfs), .AUXILIARY_FAILSAFE(afs));

    task stop_test;
        if (error_cnt == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task cyc(input integer k);
        repeat (k) @(posedge REF_CLK);
    endtask

    // one-cycle strobe on a clear or the enable write
    task pulse(input integer k);
        @(posedge REF_CLK) clr <= 6'h01 << k;
        @(posedge REF_CLK) clr <= 6'h00;
    endtask

    // note the expected bits, then hand control back at a rising edge
    task chk(input [12:0] mask, input [12:0] val);
        @(negedge REF_CLK);
        notes.push_back({mask, val});
        -> note_ev;
        @(posedge REF_CLK);
    endtask

    initial forever begin
        @(note_ev);
        n = notes.pop_front();
        checked = checked + 1;
        if ((obs & n[25:13]) !== (n[12:0] & n[25:13])) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, n[12:0] & n[25:13], obs & n[25:13]);
        end
    end

    initial begin
        #(100 * 8000);
        error_cnt = error_cnt + 1;
        stop_test;
    end

    initial begin
        void'($urandom(25489));
        cyc(20);
        RST_B <= 1'b1;
        chk(13'h0FFF, 13'h0010);
        en_d <= 1'b1;
        pulse(5);
        chk(13'h0070, 13'h0070);
        sdf <= 1'b1;
        pulse(4);
        chk(13'h0070, 13'h0070);
        sdf <= 1'b0;
        pulse(4);
        chk(13'h0070, 13'h0020);
        for (i = 0; i < 2; i = i + 1) begin
            tap <= i ? 5'h1F : 5'h00;
            cyc(2);
            pulse(3);
            pulse(4);
            chk(13'h0058, 13'h0058);
            tap <= 5'($urandom % 30 + 1);
            cyc(1);
            pulse(3);
            pulse(4);
            chk(13'h0058, 13'h0000);
        end
        // 0 crystal one low, 1 crystal one high, 2 crystal two, 3 crystal one high bypassed
        for (m = 0; m < 4; m = m + 1) begin
            fm = 13'h0001 << ((m == 2) ? 2 : (m == 0 ? 0 : 1));
            sm = (m == 2) ? 13'h0100 : 13'h0080;
            mx = (m == 1 || m == 2) ? HF : LF;
            per = (m == 2) ? 4 : 6;
            xt1_on <= (m != 2);
            xt2_on <= (m == 2);
            xt1_hf <= (m != 0);
            xt1_byp <= (m == 3);
            ref_sel <= (m == 2) ? 3'h5 : (m == 3 ? 3'h2 : 3'h0);
            msel <= (m == 2) ? 3'h5 : 3'h0;
            asel <= (m == 2) ? 3'h5 : 3'h0;
            ssel <= 3'($urandom % 4 + 1);
            cyc(6);
            xt1_stop <= (m != 2);
            xt2_stop <= (m == 2);
            cyc(6);
            ref_seen <= 1'b0;
            cyc(12);
            mk = fm | sm | 13'h1E50;
            vl = fm | sm | 13'h0A50 | ((m == 0 || m == 3) ? 13'h1000 : 13'h0000);
            chk(mk, vl);
            pulse((m == 2) ? 2 : (m == 0 ? 0 : 1));
            pulse(4);
            chk(mk & 13'h0FFF, vl);
            xt1_stop <= 1'b0;
            xt2_stop <= 1'b0;
            cyc((mx - 2) * per);
            chk(fm | sm, fm | sm);
            cyc(5 * per);
            chk(fm | sm, fm);
            pulse((m == 2) ? 2 : (m == 0 ? 0 : 1));
            pulse(4);
            cyc(2);
            chk(mk & 13'h0FFF, 13'h0020);
        end
        stop_test;
    end
endmodule // test_ofs_failsafe
